//--- src/wrc_consts.vh
// constants for the wakeup receiver configuration register bank
`ifndef WRC_CONSTS_VH
`define WRC_CONSTS_VH

// register addresses (5-bit address field of the serial command)
`define WRC_ADDR_MODE      5'h00
`define WRC_ADDR_FEAT      5'h01
`define WRC_ADDR_TOL       5'h02
`define WRC_ADDR_SLICE     5'h03
`define WRC_ADDR_OFFG      5'h04
`define WRC_ADDR_PAT2      5'h05
`define WRC_ADDR_PAT1      5'h06
`define WRC_ADDR_TOBR      5'h07
`define WRC_ADDR_AWAKE     5'h08
`define WRC_ADDR_RSV9      5'h09
`define WRC_ADDR_SIG       5'h0a
`define WRC_ADDR_RSV11     5'h0b
`define WRC_ADDR_RSV12     5'h0c
`define WRC_ADDR_FWAKE     5'h0d
`define WRC_ADDR_LAST      5'h0d

// reset values
`define WRC_RST_MODE       8'h0e
`define WRC_RST_FEAT       8'h23
`define WRC_RST_TOL        8'h00
`define WRC_RST_SLICE      8'h20
`define WRC_RST_OFFG       8'h10
`define WRC_RST_PAT2       8'h69
`define WRC_RST_PAT1       8'h96
`define WRC_RST_TOBR       8'h0b
`define WRC_RST_AWAKE      8'h00
`define WRC_RST_FWAKE      8'h00

// writable bit masks
`define WRC_WMASK_MODE     8'h3f
`define WRC_WMASK_TOL      8'he3
`define WRC_WMASK_AWAKE    8'h07

// command modes (top two bits)
`define WRC_MODE_WRITE     2'b00
`define WRC_MODE_READ      2'b01
`define WRC_MODE_DIRECT    2'b11

// direct commands
`define WRC_DC_CLEAR_WAKE  5'h00
`define WRC_DC_RESET_SIG   5'h01
`define WRC_DC_TRIM_OSC    5'h02
`define WRC_DC_CLEAR_FALSE 5'h03
`define WRC_DC_PRESET      5'h04

`endif

//--- src/wrc_serial_rx.v
// serial command front end: samples on falling sclk, frames bytes
`timescale 1ns/1ns
`default_nettype none
module wrc_serial_rx (
    // system
    input  wire       clock,
    input  wire       srst,
    // serial pins, synchronous to clock
    input  wire       cs,
    input  wire       sclk,
    input  wire       sdi,
    // framed output
    output reg        cmd_valid,
    output reg  [7:0] cmd_byte,
    output reg        data_valid,
    output reg  [7:0] data_byte,
    output reg        byte_start,
    output wire       sclk_rise
);
    reg       sclk_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg       first_reg;
    wire      sclk_fall = sclk_reg & ~sclk & cs;
    wire [7:0] shifted = {shift_reg[6:0], sdi};

    assign sclk_rise = ~sclk_reg & sclk & cs;

    always @(posedge clock) begin
        if (srst) begin
            sclk_reg    <= 1'b0;
            bit_cnt_reg <= 3'd0;
            shift_reg   <= 8'h00;
            first_reg   <= 1'b1;
            cmd_valid   <= 1'b0;
            cmd_byte    <= 8'h00;
            data_valid  <= 1'b0;
            data_byte   <= 8'h00;
            byte_start  <= 1'b0;
        end else begin
            sclk_reg   <= sclk;
            cmd_valid  <= 1'b0;
            data_valid <= 1'b0;
            byte_start <= 1'b0;
            if (!cs) begin
                // cs low ends any command; next byte is a command again
                bit_cnt_reg <= 3'd0;
                first_reg   <= 1'b1;
            end else if (sclk_fall) begin
                shift_reg   <= shifted;
                bit_cnt_reg <= bit_cnt_reg + 3'd1;
                if (bit_cnt_reg == 3'd7) begin
                    first_reg <= 1'b0;
                    if (first_reg) begin
                        cmd_valid <= 1'b1;
                        cmd_byte  <= shifted;
                    end else begin
                        data_valid <= 1'b1;
                        data_byte  <= shifted;
                    end
                    byte_start <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- src/wrc_regbank.v
// configuration and status register bank behind the serial port
`timescale 1ns/1ns
`default_nettype none
`include "wrc_consts.vh"
module wrc_regbank (
    // system
    input  wire       clock,
    input  wire       srst,
    // serial pins
    input  wire       cs,
    input  wire       sclk,
    input  wire       sdi,
    output reg        sdo,
    output wire       sdo_oe,
    // status from the analog channel
    input  wire [4:0] signal_strength,
    input  wire       false_wakeup_event,
    // direct command strobes to other logic
    output reg        clear_wake_pulse,
    output reg        reset_strength_pulse,
    output reg        trim_osc_pulse,
    // mode_control fields
    output wire       on_off_en,
    output wire       reserved_mux_bit,
    output wire [1:0] mode_reserved,
    output wire       channel_en,
    output wire       power_down,
    // feature_enables fields
    output wire       slicer_absolute_ref,
    output wire       gain_first_burst_only,
    output wire       gain_bidirectional,
    output wire       antenna_damper_en,
    output wire       biphase_decoder_en,
    output wire       double_pattern_en,
    output wire       correlation_en,
    output wire       crystal_en,
    // tolerance and slicer fields
    output wire       slicer_threshold_reduce,
    output wire [1:0] pattern_tolerance,
    output wire [1:0] wakeup_freq_tolerance,
    output wire       slicer_small_hysteresis,
    output wire       hysteresis_rising_only,
    output wire [2:0] slicer_time_constant,
    output wire [2:0] envelope_time_constant,
    // timing and gain fields
    output wire [1:0] off_time_code,
    output wire [3:0] off_time_ms,
    output wire [1:0] damping_resistor_code,
    output wire [3:0] gain_reduction_code,
    output wire [15:0] wakeup_pattern,
    output wire [2:0] timeout_code,
    output wire [4:0] bit_rate_code,
    output wire [2:0] artificial_wakeup_code,
    output wire [7:0] false_wakeup_count
);
    reg  [7:0] mode_control_reg;
    reg  [7:0] feature_enables_reg;
    reg  [7:0] tolerance_settings_reg;
    reg  [7:0] slicer_envelope_config_reg;
    reg  [7:0] offtime_damping_gain_reg;
    reg  [7:0] pattern_second_byte_reg;
    reg  [7:0] pattern_first_byte_reg;
    reg  [7:0] timeout_bitrate_reg;
    reg  [7:0] artificial_wakeup_period_reg;
    reg  [7:0] false_wakeup_count_reg;
    reg  [4:0] addr_reg;
    reg  [1:0] mode_reg;
    reg  [7:0] rd_shift_reg;

    wire       cmd_valid;
    wire [7:0] cmd_byte;
    wire       data_valid;
    wire [7:0] data_byte;
    wire       byte_start;
    wire       sclk_rise;

    wrc_serial_rx u_rx (
        .clock      (clock),
        .srst       (srst),
        .cs         (cs),
        .sclk       (sclk),
        .sdi        (sdi),
        .cmd_valid  (cmd_valid),
        .cmd_byte   (cmd_byte),
        .data_valid (data_valid),
        .data_byte  (data_byte),
        .byte_start (byte_start),
        .sclk_rise  (sclk_rise)
    );

    // read mux over the register map; unmapped and reserved read zero
    function [7:0] read_reg;
        input [4:0] a;
        begin
            case (a)
                `WRC_ADDR_MODE:  read_reg = mode_control_reg;
                `WRC_ADDR_FEAT:  read_reg = feature_enables_reg;
                `WRC_ADDR_TOL:   read_reg = tolerance_settings_reg;
                `WRC_ADDR_SLICE: read_reg = slicer_envelope_config_reg;
                `WRC_ADDR_OFFG:  read_reg = offtime_damping_gain_reg;
                `WRC_ADDR_PAT2:  read_reg = pattern_second_byte_reg;
                `WRC_ADDR_PAT1:  read_reg = pattern_first_byte_reg;
                `WRC_ADDR_TOBR:  read_reg = timeout_bitrate_reg;
                `WRC_ADDR_AWAKE: read_reg = artificial_wakeup_period_reg;
                `WRC_ADDR_SIG:   read_reg = {3'b000, signal_strength};
                `WRC_ADDR_FWAKE: read_reg = false_wakeup_count_reg;
                default:         read_reg = 8'h00;
            endcase
        end
    endfunction

    wire       is_direct  = cmd_valid && (cmd_byte[7:6] == `WRC_MODE_DIRECT);
    wire [4:0] dc_code    = cmd_byte[5:1];
    wire       do_preset  = is_direct && (dc_code == `WRC_DC_PRESET);
    wire       do_clr_fw  = is_direct && (dc_code == `WRC_DC_CLEAR_FALSE);
    wire       wr_strobe  = data_valid && (mode_reg == `WRC_MODE_WRITE);
    // auto-increment: the address advances after each data byte
    wire [4:0] next_addr  = addr_reg + 5'd1;
    wire       rd_load    = byte_start && (cmd_valid ? (cmd_byte[7:6] == `WRC_MODE_READ)
                                                     : (mode_reg == `WRC_MODE_READ));
    wire [4:0] rd_addr    = cmd_valid ? cmd_byte[5:1] : next_addr;

    // address, mode and direct command strobes
    always @(posedge clock) begin
        if (srst) begin
            addr_reg             <= 5'd0;
            mode_reg             <= `WRC_MODE_WRITE;
            clear_wake_pulse     <= 1'b0;
            reset_strength_pulse <= 1'b0;
            trim_osc_pulse       <= 1'b0;
        end else begin
            clear_wake_pulse     <= is_direct && (dc_code == `WRC_DC_CLEAR_WAKE);
            reset_strength_pulse <= is_direct && (dc_code == `WRC_DC_RESET_SIG);
            trim_osc_pulse       <= is_direct && (dc_code == `WRC_DC_TRIM_OSC);
            if (cmd_valid) begin
                addr_reg <= cmd_byte[5:1];
                mode_reg <= cmd_byte[7:6];
            end else if (data_valid) begin
                addr_reg <= next_addr;
            end
        end
    end

    // read path: byte loaded at each byte end in read mode, shifted out on rising sclk
    always @(posedge clock) begin
        if (srst) begin
            rd_shift_reg <= 8'h00;
            sdo          <= 1'b0;
        end else if (rd_load) begin
            rd_shift_reg <= read_reg(rd_addr);
            sdo          <= 1'b0;
        end else if (sclk_rise && mode_reg == `WRC_MODE_READ && !cmd_valid) begin
            sdo          <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end
    // sdo released whenever cs is low
    assign sdo_oe = cs;

    // configuration registers
    always @(posedge clock) begin
        if (srst || do_preset) begin
            mode_control_reg             <= `WRC_RST_MODE;
            feature_enables_reg          <= `WRC_RST_FEAT;
            tolerance_settings_reg       <= `WRC_RST_TOL;
            slicer_envelope_config_reg   <= `WRC_RST_SLICE;
            offtime_damping_gain_reg     <= `WRC_RST_OFFG;
            pattern_second_byte_reg      <= `WRC_RST_PAT2;
            pattern_first_byte_reg       <= `WRC_RST_PAT1;
            timeout_bitrate_reg          <= `WRC_RST_TOBR;
            artificial_wakeup_period_reg <= `WRC_RST_AWAKE;
        end else if (wr_strobe) begin
            case (addr_reg)
                // reserved bit 4 kept at 0 so a stray write cannot set it
                `WRC_ADDR_MODE:  mode_control_reg <= data_byte & `WRC_WMASK_MODE & 8'hef;
                `WRC_ADDR_FEAT:  feature_enables_reg <= data_byte;
                `WRC_ADDR_TOL:   tolerance_settings_reg <= data_byte & `WRC_WMASK_TOL;
                `WRC_ADDR_SLICE: slicer_envelope_config_reg <= data_byte;
                `WRC_ADDR_OFFG:  offtime_damping_gain_reg <= data_byte;
                `WRC_ADDR_PAT2:  pattern_second_byte_reg <= data_byte;
                `WRC_ADDR_PAT1:  pattern_first_byte_reg <= data_byte;
                `WRC_ADDR_TOBR:  timeout_bitrate_reg <= data_byte;
                `WRC_ADDR_AWAKE: artificial_wakeup_period_reg <= data_byte & `WRC_WMASK_AWAKE;
                default:         ;
            endcase
        end
    end

    // false wakeup counter: a same-cycle event below top is counted after the host clear; saturates at top
    always @(posedge clock) begin
        if (srst || do_preset) begin
            false_wakeup_count_reg <= `WRC_RST_FWAKE;
        end else if (false_wakeup_event && false_wakeup_count_reg != 8'hff) begin
            // below 8'hff a new event in the clear cycle wins, so it is not lost
            false_wakeup_count_reg <= do_clr_fw ? 8'h01 : false_wakeup_count_reg + 8'h01;
        end else if (do_clr_fw) begin
            false_wakeup_count_reg <= 8'h00;
        end else if (wr_strobe && addr_reg == `WRC_ADDR_FWAKE) begin
            false_wakeup_count_reg <= data_byte;
        end
    end

    // field outputs
    assign on_off_en               = mode_control_reg[5];
    assign reserved_mux_bit        = mode_control_reg[4];
    assign mode_reserved           = mode_control_reg[3:2];
    assign channel_en              = mode_control_reg[1];
    assign power_down              = mode_control_reg[0];
    assign slicer_absolute_ref     = feature_enables_reg[7];
    assign gain_first_burst_only   = feature_enables_reg[6];
    assign gain_bidirectional      = feature_enables_reg[5];
    assign antenna_damper_en       = feature_enables_reg[4];
    assign biphase_decoder_en      = feature_enables_reg[3];
    assign double_pattern_en       = feature_enables_reg[2];
    assign correlation_en          = feature_enables_reg[1];
    assign crystal_en              = feature_enables_reg[0];
    assign slicer_threshold_reduce = tolerance_settings_reg[7];
    assign pattern_tolerance       = tolerance_settings_reg[6:5];
    assign wakeup_freq_tolerance   = tolerance_settings_reg[1:0];
    assign slicer_small_hysteresis = slicer_envelope_config_reg[7];
    assign hysteresis_rising_only  = slicer_envelope_config_reg[6];
    assign slicer_time_constant    = slicer_envelope_config_reg[5:3];
    assign envelope_time_constant  = slicer_envelope_config_reg[2:0];
    assign off_time_code           = offtime_damping_gain_reg[7:6];
    // off interval doubles per code step
    assign off_time_ms             = 4'd1 << off_time_code;
    assign damping_resistor_code   = offtime_damping_gain_reg[5:4];
    assign gain_reduction_code     = offtime_damping_gain_reg[3:0];
    assign wakeup_pattern          = {pattern_first_byte_reg, pattern_second_byte_reg};
    assign timeout_code            = timeout_bitrate_reg[7:5];
    assign bit_rate_code           = timeout_bitrate_reg[4:0];
    assign artificial_wakeup_code  = artificial_wakeup_period_reg[2:0];
    assign false_wakeup_count      = false_wakeup_count_reg;
endmodule
`default_nettype wire

//--- testbench/wrc_regbank_asserts.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module wrc_regbank_asserts (
    // system
    input wire logic        clock,
    input wire logic        srst,
    // serial and status
    input wire logic        cs,
    input wire logic        false_wakeup_event,
    // mode fields
    input wire logic        on_off_en,
    input wire logic        reserved_mux_bit,
    input wire logic [1:0]  mode_reserved,
    input wire logic        channel_en,
    input wire logic        power_down,
    // feature fields
    input wire logic        gain_bidirectional,
    input wire logic        correlation_en,
    input wire logic        crystal_en,
    // timing and pattern fields
    input wire logic [1:0]  off_time_code,
    input wire logic [3:0]  off_time_ms,
    input wire logic [1:0]  damping_resistor_code,
    input wire logic [15:0] wakeup_pattern,
    input wire logic [4:0]  bit_rate_code,
    input wire logic [7:0]  false_wakeup_count
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // wakeup pattern untouched once the serial port has been idle four cycles
    sequence quiet_bus;
        !cs [*4];
    endsequence
    sequence counted_event;
        false_wakeup_event && (false_wakeup_count != 8'hff);
    endsequence

    mode_reset_a: assert property ($fell(srst) |->
        {on_off_en, reserved_mux_bit, mode_reserved, channel_en, power_down} == 6'h0e)
        else $error("mode fields wrong after reset");
    gain_reset_a: assert property ($fell(srst) |->
        gain_bidirectional && correlation_en && crystal_en)
        else $error("feature enables wrong after reset");
    pattern_reset_a: assert property ($fell(srst) |-> wakeup_pattern == 16'h9669)
        else $error("wakeup pattern wrong after reset");
    timing_reset_a: assert property ($fell(srst) |->
        off_time_code == 2'h0 && damping_resistor_code == 2'h1 && bit_rate_code == 5'h0b)
        else $error("timing fields wrong after reset");
    offtime_map_a: assert property (off_time_ms == (4'h1 << off_time_code))
        else $error("off interval does not follow its code");
    reserved_low_a: assert property (reserved_mux_bit == 1'b0)
        else $error("reserved mode bit set");
    config_hold_a: assert property (quiet_bus |-> $stable(wakeup_pattern))
        else $error("pattern changed with the port idle");
    false_count_a: assert property (counted_event |=>
        false_wakeup_count == $past(false_wakeup_count) + 8'h01)
        else $error("false wakeup count did not step");
endmodule
`default_nettype wire

//--- testbench/wrc_host_model.sv
// host microcontroller model speaking the four-wire serial port
`timescale 1ns/1ns
`default_nettype none
module wrc_host_model (
    // system
    input  wire logic clock,
    // serial pins toward the bank
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output var  logic cs,
    output var  logic sclk,
    output var  logic sdi
);
    // idle lines sit at their pull-down level
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one 16-bit frame; slow sclk since the bank oversamples it
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] din, output logic [7:0] dout);
        logic [15:0] w;
        w = {cmd, din};
        dout = 8'h00;
        if (cmd[7:1] == 7'h00) w[4] = 1'b0; // never set the reserved mode bit
        step(1);
        cs = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            step(1);
            sdi = w[i];
            sclk = 1'b1;
            step(3);
            if (i < 8) dout[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1'b0;
            step(2);
        end
        step(3);
        sdi = 1'b0;
        cs = 1'b0;
        step(3);
    endtask
endmodule
`default_nettype wire

//--- testbench/wrc_regbank_tb.sv
// self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
`include "wrc_consts.vh"
module wrc_regbank_tb;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  strength = 5'h15;
    logic        fw_event = 1'b0;
    wire         cs, sclk, sdi, sdo, sdo_oe, on_off_en;
    wire  [3:0]  off_time_ms;
    wire  [15:0] wakeup_pattern;
    wire  [4:0]  bit_rate_code;
    wire  [4:0]  f_mode;
    wire  [7:0]  f_feat;
    wire  [4:0]  f_tol;
    wire  [7:0]  f_slice;
    wire  [7:0]  f_offg;
    wire  [2:0]  f_tout;
    wire  [2:0]  f_awake;
    wire  [7:0]  fw_count;
    wire  [2:0]  pulses;
    logic [11:0] pulse_cnt;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [7:0]  rd;
    logic [7:0]  deflt [0:13] = '{8'h0e, 8'h23, 8'h00, 8'h20, 8'h10, 8'h69, 8'h96,
                                  8'h0b, 8'h00, 8'h00, 8'h15, 8'h00, 8'h00, 8'h00};
    logic [7:0]  wdat [0:13] = '{8'hff, 8'hd5, 8'hff, 8'h5a, 8'hc7, 8'ha5, 8'h3c,
                                 8'he4, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h5c};
    logic [7:0]  rexp [0:13] = '{8'h2f, 8'hd5, 8'he3, 8'h5a, 8'hc7, 8'ha5, 8'h3c,
                                 8'he4, 8'h07, 8'h00, 8'h15, 8'h00, 8'h00, 8'h5c};

    always #4 clock = ~clock;

    // one nibble per command strobe, so a stuck or doubled pulse shows in the count
    always @(posedge clock) begin
        if (srst) begin
            pulse_cnt <= 12'h000;
        end else begin
            pulse_cnt <= pulse_cnt + {3'h0, pulses[2], 3'h0, pulses[1], 3'h0, pulses[0]};
        end
    end

    wrc_host_model u_wrc_host_model (.clock(clock), .sdo(sdo), .sdo_oe(sdo_oe), .cs(cs), .sclk(sclk), .sdi(sdi));

    wrc_regbank u_wrc_regbank (.clock(clock), .srst(srst), .cs(cs), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .signal_strength(strength), .false_wakeup_event(fw_event),
        .clear_wake_pulse(pulses[0]), .reset_strength_pulse(pulses[1]), .trim_osc_pulse(pulses[2]),
        .on_off_en(on_off_en), .reserved_mux_bit(f_mode[4]), .mode_reserved(f_mode[3:2]),
        .channel_en(f_mode[1]), .power_down(f_mode[0]), .slicer_absolute_ref(f_feat[7]),
        .gain_first_burst_only(f_feat[6]), .gain_bidirectional(f_feat[5]), .antenna_damper_en(f_feat[4]),
        .biphase_decoder_en(f_feat[3]), .double_pattern_en(f_feat[2]), .correlation_en(f_feat[1]),
        .crystal_en(f_feat[0]), .slicer_threshold_reduce(f_tol[4]), .pattern_tolerance(f_tol[3:2]),
        .wakeup_freq_tolerance(f_tol[1:0]), .slicer_small_hysteresis(f_slice[7]),
        .hysteresis_rising_only(f_slice[6]), .slicer_time_constant(f_slice[5:3]),
        .envelope_time_constant(f_slice[2:0]), .off_time_code(f_offg[7:6]), .off_time_ms(off_time_ms),
        .damping_resistor_code(f_offg[5:4]), .gain_reduction_code(f_offg[3:0]),
        .wakeup_pattern(wakeup_pattern), .timeout_code(f_tout), .bit_rate_code(bit_rate_code),
        .artificial_wakeup_code(f_awake), .false_wakeup_count(fw_count));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [1:0] m, input logic [4:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_wrc_host_model.xfer({m, a, 1'b0}, d, unused);
    endtask

    task automatic read_check(input logic [4:0] a, input logic [7:0] exp);
        u_wrc_host_model.xfer({`WRC_MODE_READ, a, 1'b0}, 8'h00, rd);
        check("register read", {8'h00, exp}, {8'h00, rd});
    endtask

    task automatic check_defaults;
        for (int i = 0; i < 14; i++) read_check(i[4:0], deflt[i]);
    endtask

    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge clock);
        #1;
        srst = 1'b0;
        check_defaults();
        for (int i = 0; i < 14; i++) send(`WRC_MODE_WRITE, i[4:0], wdat[i]);
        for (int i = 0; i < 14; i++) read_check(i[4:0], rexp[i]);
        check("on off enable", 16'h0001, {15'h0, on_off_en});
        check("wakeup pattern", 16'h3ca5, wakeup_pattern);
        check("bit rate code", 16'h0004, {11'h0, bit_rate_code});
        check("mode fields", {11'h0, rexp[0][4:0]}, {11'h0, f_mode});
        check("feature fields", {8'h0, rexp[1]}, {8'h0, f_feat});
        check("tolerance fields", {11'h0, rexp[2][7:5], rexp[2][1:0]}, {11'h0, f_tol});
        check("slicer fields", {8'h0, rexp[3]}, {8'h0, f_slice});
        check("gain fields", {8'h0, rexp[4]}, {8'h0, f_offg});
        check("wake timing", {10'h0, rexp[7][7:5], rexp[8][2:0]}, {10'h0, f_tout, f_awake});
        check("false wakeup count", {8'h0, rexp[13]}, {8'h0, fw_count});
        // spare mode must leave the bank alone
        send(2'b10, `WRC_ADDR_PAT1, 8'h00);
        read_check(`WRC_ADDR_PAT1, 8'h3c);
        send(`WRC_MODE_WRITE, 5'h1f, 8'hff);
        read_check(5'h1f, 8'h00);
        for (int c = 0; c < 4; c++) begin
            send(`WRC_MODE_WRITE, `WRC_ADDR_OFFG, {c[1:0], 6'h10});
            check("off interval", 16'h0001 << c, {12'h0, off_time_ms});
        end
        fw_event = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        fw_event = 1'b0;
        read_check(`WRC_ADDR_FWAKE, 8'h5f);
        send(`WRC_MODE_DIRECT, `WRC_DC_CLEAR_FALSE, 8'h00);
        read_check(`WRC_ADDR_FWAKE, 8'h00);
        send(`WRC_MODE_DIRECT, `WRC_DC_PRESET, 8'h00);
        check_defaults();
        send(`WRC_MODE_WRITE, `WRC_ADDR_MODE, 8'h02);
        read_check(`WRC_ADDR_MODE, 8'h02);
        // each strobe command gives exactly one single-cycle pulse on its own line
        for (int k = 0; k < 3; k++) send(`WRC_MODE_DIRECT, k[4:0], 8'h00);
        check("command pulses", 16'h0111, {4'h0, pulse_cnt});
        // second reset in mid-run restores the pattern
        send(`WRC_MODE_WRITE, `WRC_ADDR_PAT2, 8'h00);
        srst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        srst = 1'b0;
        read_check(`WRC_ADDR_PAT2, 8'h69);
        complete_run();
    end
endmodule

bind wrc_regbank wrc_regbank_asserts u_wrc_regbank_asserts (
    .clock(clock), .srst(srst), .cs(cs), .false_wakeup_event(false_wakeup_event),
    .on_off_en(on_off_en), .reserved_mux_bit(reserved_mux_bit), .mode_reserved(mode_reserved),
    .channel_en(channel_en), .power_down(power_down), .gain_bidirectional(gain_bidirectional),
    .correlation_en(correlation_en), .crystal_en(crystal_en), .off_time_code(off_time_code),
    .off_time_ms(off_time_ms), .damping_resistor_code(damping_resistor_code),
    .wakeup_pattern(wakeup_pattern), .bit_rate_code(bit_rate_code), .false_wakeup_count(false_wakeup_count));
`default_nettype wire
